// ==== rtl/pwts_pkg.sv ====
// shared constants of the ten-bit pwm block with per-channel timer select
package pwts_pkg;
  // structure of the block
  localparam int NUM_TMR   = 3;          // pwm timers: two, four and six
  localparam int NUM_CH    = 2;          // pwm channels
  localparam int NUM_CC    = 4;          // capture/compare units served
  localparam int ADDR_W    = 12;         // axi byte address width
  localparam int IDX_W     = 10;         // register index width
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_CC_SEL     = 10'h21e; // capture_compare_timer_select
  localparam logic [9:0] IDX_PWM_SEL    = 10'h21f; // pwm_timer_select
  localparam logic [9:0] IDX_TMR_CTRL0  = 10'h220; // timer control, +timer
  localparam logic [9:0] IDX_TMR_PER0   = 10'h224; // selected_period_reg, +timer
  localparam logic [9:0] IDX_TMR_CNT0   = 10'h228; // selected_timer_count, +timer
  localparam logic [9:0] IDX_DUTY_HI0   = 10'h22c; // duty_high_reg, +channel
  localparam logic [9:0] IDX_DUTY_LO0   = 10'h22e; // duty_low_reg, +channel
  localparam logic [9:0] IDX_CH_CTRL0   = 10'h230; // pwm_channel_control, +ch
  localparam logic [9:0] IDX_PIN_DIR    = 10'h232; // pin_direction_control
  // reset values
  localparam logic [7:0] CC_SEL_RST     = 8'h55;   // every unit on pair one
  localparam logic [7:0] PWM_SEL_RST    = 8'h14;   // every channel on timer two
  localparam logic [1:0] PIN_DIR_RST    = 2'h3;    // all pins input
  // field positions
  localparam int PWM_SEL_LSB   = 2;   // channel c field at 2+2c
  localparam int DUTY_LO_LSB   = 6;   // two low duty bits at 7:6
  localparam int CTRL_EN_BIT   = 7;   // channel enable
  localparam int CTRL_OUT_BIT  = 5;   // read-only output level
  localparam int CTRL_POL_BIT  = 4;   // output_invert_bit
  localparam int TCTRL_ON_BIT  = 0;   // timer run
  localparam int TCTRL_PS_LSB  = 1;   // prescale select at 2:1
  // timing: timer counts at system clock divided by four
  localparam int CLK_PERIOD_NS = 4;
  localparam int SUB_STEPS     = 4;
  // axi answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pwts_pkg

// ==== rtl/pwts_timebase.sv ====
// one pwm timer: prescaler, two sub-count bits and eight-bit count
module pwts_timebase (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       timerOn,     // timer runs
  input  wire logic       sleep,       // freeze everything
  input  wire logic [1:0] prescaleSel, // 1, 4, 16 or 64
  input  wire logic [7:0] period,      // period register
  output logic      [9:0] timeBase,    // {count, sub-count}
  output logic            baseStep,    // time base advanced this cycle
  output logic            periodStart  // count just cleared at period end
);
  logic [5:0] presc_reg;  // prescale divider
  logic [1:0] sub_reg;    // two sub-count bits
  logic [7:0] tmr_reg;    // eight-bit count
  logic       step_reg;
  logic       start_reg;
  logic       advance;
  logic       wrap;

  // last prescale count for each selection
  function automatic logic [5:0] lastCount(input logic [1:0] sel);
    case (sel)
      2'h0:    lastCount = 6'h00;
      2'h1:    lastCount = 6'h03;
      2'h2:    lastCount = 6'h0f;
      default: lastCount = 6'h3f;
    endcase
  endfunction : lastCount

  // sleep holds the count; no postscaler exists on this path
  assign advance = timerOn && !sleep
                   && (presc_reg == lastCount(prescaleSel));
  assign wrap    = (sub_reg == 2'(pwts_pkg::SUB_STEPS - 1))
                   && (tmr_reg == period);

  // prescaler
  always_ff @(posedge sys_clk) begin
    if (!rstn) presc_reg <= 6'h00;
    else if (!timerOn || advance) presc_reg <= 6'h00;
    else if (!sleep) presc_reg <= presc_reg + 6'h01;
  end

  // sub-count below the eight-bit count forms the ten-bit base
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sub_reg <= 2'h0;
      tmr_reg <= 8'h00;
    end else if (advance) begin
      sub_reg <= sub_reg + 2'h1;
      if (wrap) tmr_reg <= 8'h00;
      else if (sub_reg == 2'(pwts_pkg::SUB_STEPS - 1))
        tmr_reg <= tmr_reg + 8'h01;
    end
  end

  // event pulses for the channels
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      step_reg  <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      step_reg  <= advance;
      start_reg <= advance && wrap;
    end
  end

  assign timeBase    = {tmr_reg, sub_reg};
  assign baseStep    = step_reg;
  assign periodStart = start_reg;
endmodule : pwts_timebase

// ==== rtl/pwts_channel.sv ====
// one pwm channel: buffered duty, compare and polarity
module pwts_channel (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [9:0] timeBase,    // selected timer base
  input  wire logic       baseStep,    // base advanced
  input  wire logic       periodStart, // period begins
  input  wire logic [7:0] period,      // selected period register
  input  wire logic [7:0] dutyHigh,    // eight upper duty bits
  input  wire logic [1:0] dutyLow,     // two lower duty bits
  input  wire logic       enable,      // channel enable
  input  wire logic       invert,      // polarity
  output logic            level        // output after polarity
);
  logic [9:0] dutyBuf_reg; // working copy of duty
  logic       raw_reg;     // active-high pulse before polarity
  logic       level_reg;
  logic [9:0] newDuty;
  logic       fullDuty;

  assign newDuty  = {dutyHigh, dutyLow};
  // a duty past the last base value never meets the base
  assign fullDuty = dutyBuf_reg > {period, 2'h3};

  // latch duty and start the pulse at each period start
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dutyBuf_reg <= 10'h000;
      raw_reg     <= 1'b0;
    end else if (periodStart) begin
      dutyBuf_reg <= newDuty;
      raw_reg     <= (newDuty != 10'h000);
    end else if (baseStep && timeBase == dutyBuf_reg && !fullDuty) begin
      raw_reg     <= 1'b0;
    end
  end

  // enable gates, then polarity inverts
  always_ff @(posedge sys_clk) begin
    if (!rstn) level_reg <= 1'b0;
    else level_reg <= (enable && raw_reg) ^ invert;
  end

  assign level = level_reg;
endmodule : pwts_channel

// ==== rtl/pwts_top.sv ====
// ten-bit pwm block with timer selection and axi4-lite registers
module pwts_top (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  // axi4-lite slave
  input  wire logic [pwts_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [pwts_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // device side
  input  wire logic                        sleepReq,       // sleep, async
  output logic [pwts_pkg::NUM_CH-1:0]      pwmOut,         // pin level
  output logic [pwts_pkg::NUM_CH-1:0]      pwmOe,          // pin drive
  output logic [2*pwts_pkg::NUM_CC-1:0]    ccTimerPair     // pair index
);
  // software registers
  logic [7:0] ccSel_reg;                       // capture timer fields
  logic [7:0] pwmSel_reg;                      // pwm timer fields
  logic [2:0] tmrCtrl_reg  [pwts_pkg::NUM_TMR]; // {prescale, on}
  logic [7:0] tmrPer_reg   [pwts_pkg::NUM_TMR]; // period per timer
  logic [7:0] dutyHi_reg   [pwts_pkg::NUM_CH];  // duty upper byte
  logic [1:0] dutyLo_reg   [pwts_pkg::NUM_CH];  // duty lower bits
  logic [1:0] chCtrl_reg   [pwts_pkg::NUM_CH];  // {enable, polarity}
  logic [1:0] pinDir_reg;                      // 1 = input
  // bus state
  logic        awready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;
  // sleep synchroniser
  logic        sleepS1_reg;
  logic        sleepS2_reg;
  logic        sleepS3_reg;
  logic        sleep_reg;
  // output flops
  logic [pwts_pkg::NUM_CH-1:0]   pwmOut_reg;
  logic [pwts_pkg::NUM_CH-1:0]   pwmOe_reg;
  logic [2*pwts_pkg::NUM_CC-1:0] ccPair_reg;
  // timer and channel wiring
  logic [9:0] tBase   [pwts_pkg::NUM_TMR];
  logic       tStep   [pwts_pkg::NUM_TMR];
  logic       tStart  [pwts_pkg::NUM_TMR];
  logic       chLevel [pwts_pkg::NUM_CH];
  logic [1:0] chTmr   [pwts_pkg::NUM_CH];
  // decode
  logic [9:0]  wrIdx;
  logic [9:0]  rdIdx;
  logic        wrFire;
  logic        rdFire;
  logic        wrOk;
  logic        rdOk;
  logic [7:0]  rdByte;

  // timer field to timer index; reserved code falls back to timer two
  function automatic logic [1:0] timerIndex(input logic [1:0] field);
    case (field)
      2'h1:    timerIndex = 2'h0;
      2'h2:    timerIndex = 2'h1;
      2'h3:    timerIndex = 2'h2;
      default: timerIndex = 2'h0;
    endcase
  endfunction : timerIndex

  // true when idx lies in a block of n registers starting at base
  function automatic logic inBlock(input logic [9:0] idx,
                                   input logic [9:0] base,
                                   input int n);
    inBlock = (idx >= base) && (idx < base + 10'(n));
  endfunction : inBlock

  // sleep comes from outside; counted once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sleepS1_reg <= 1'b0;
      sleepS2_reg <= 1'b0;
      sleepS3_reg <= 1'b0;
      sleep_reg   <= 1'b0;
    end else begin
      sleepS1_reg <= sleepReq;
      sleepS2_reg <= sleepS1_reg;
      sleepS3_reg <= sleepS2_reg;
      if (sleepS2_reg == sleepS3_reg) sleep_reg <= sleepS3_reg;
    end
  end

  // timers two, four and six
  for (genvar t = 0; t < pwts_pkg::NUM_TMR; t++) begin : gTmr
    pwts_timebase uTmr (
      .sys_clk     (sys_clk),
      .rstn        (rstn),
      .timerOn     (tmrCtrl_reg[t][pwts_pkg::TCTRL_ON_BIT]),
      .sleep       (sleep_reg),
      .prescaleSel (tmrCtrl_reg[t][pwts_pkg::TCTRL_PS_LSB +: 2]),
      .period      (tmrPer_reg[t]),
      .timeBase    (tBase[t]),
      .baseStep    (tStep[t]),
      .periodStart (tStart[t])
    );
  end

  // channels take base, events and period from their chosen timer
  for (genvar c = 0; c < pwts_pkg::NUM_CH; c++) begin : gCh
    assign chTmr[c] = timerIndex(
      pwmSel_reg[pwts_pkg::PWM_SEL_LSB + 2*c +: 2]);
    pwts_channel uCh (
      .sys_clk     (sys_clk),
      .rstn        (rstn),
      .timeBase    (tBase[chTmr[c]]),
      .baseStep    (tStep[chTmr[c]]),
      .periodStart (tStart[chTmr[c]]),
      .period      (tmrPer_reg[chTmr[c]]),
      .dutyHigh    (dutyHi_reg[c]),
      .dutyLow     (dutyLo_reg[c]),
      .enable      (chCtrl_reg[c][1]),
      .invert      (chCtrl_reg[c][0]),
      .level       (chLevel[c])
    );
  end

  // pin level and drive; drive only once direction is set to output
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pwmOut_reg <= '0;
      pwmOe_reg  <= '0;
    end else begin
      for (int c = 0; c < pwts_pkg::NUM_CH; c++) begin
        pwmOut_reg[c] <= chLevel[c];
        pwmOe_reg[c]  <= !pinDir_reg[c];
      end
    end
  end

  // capture units learn which timer pair backs them
  always_ff @(posedge sys_clk) begin
    if (!rstn) ccPair_reg <= '0;
    else begin
      for (int k = 0; k < pwts_pkg::NUM_CC; k++)
        ccPair_reg[2*k +: 2] <= timerIndex(ccSel_reg[2*k +: 2]);
    end
  end

  // write side: take address and data together, ready for one cycle
  assign wrIdx  = s_axi_awaddr[pwts_pkg::ADDR_W-1:2];
  assign wrFire = s_axi_awvalid && s_axi_wvalid && !awready_reg
                  && !bvalid_reg;
  assign wrOk   = (wrIdx == pwts_pkg::IDX_CC_SEL)
               || (wrIdx == pwts_pkg::IDX_PWM_SEL)
               || (wrIdx == pwts_pkg::IDX_PIN_DIR)
               || inBlock(wrIdx, pwts_pkg::IDX_TMR_CTRL0, pwts_pkg::NUM_TMR)
               || inBlock(wrIdx, pwts_pkg::IDX_TMR_PER0, pwts_pkg::NUM_TMR)
               || inBlock(wrIdx, pwts_pkg::IDX_DUTY_HI0, pwts_pkg::NUM_CH)
               || inBlock(wrIdx, pwts_pkg::IDX_DUTY_LO0, pwts_pkg::NUM_CH)
               || inBlock(wrIdx, pwts_pkg::IDX_CH_CTRL0, pwts_pkg::NUM_CH);

  // write handshake and response; counts are read-only and answer error
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      awready_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= pwts_pkg::RESP_OKAY;
    end else begin
      awready_reg <= wrFire;
      if (awready_reg) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wrOk ? pwts_pkg::RESP_OKAY : pwts_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // register stores; only byte lane zero carries data
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ccSel_reg  <= pwts_pkg::CC_SEL_RST;
      pwmSel_reg <= pwts_pkg::PWM_SEL_RST;
      pinDir_reg <= pwts_pkg::PIN_DIR_RST;
      for (int t = 0; t < pwts_pkg::NUM_TMR; t++) begin
        tmrCtrl_reg[t] <= 3'h0;
        tmrPer_reg[t]  <= 8'hff;
      end
      for (int c = 0; c < pwts_pkg::NUM_CH; c++) begin
        dutyHi_reg[c] <= 8'h00;
        dutyLo_reg[c] <= 2'h0;
        chCtrl_reg[c] <= 2'h0;
      end
    end else if (awready_reg && s_axi_wstrb[0]) begin
      if (wrIdx == pwts_pkg::IDX_CC_SEL) ccSel_reg <= s_axi_wdata[7:0];
      if (wrIdx == pwts_pkg::IDX_PWM_SEL)
        pwmSel_reg <= s_axi_wdata[7:0] & 8'h3c;
      if (wrIdx == pwts_pkg::IDX_PIN_DIR) pinDir_reg <= s_axi_wdata[1:0];
      for (int t = 0; t < pwts_pkg::NUM_TMR; t++) begin
        if (wrIdx == pwts_pkg::IDX_TMR_CTRL0 + 10'(t))
          tmrCtrl_reg[t] <= s_axi_wdata[2:0];
        if (wrIdx == pwts_pkg::IDX_TMR_PER0 + 10'(t))
          tmrPer_reg[t] <= s_axi_wdata[7:0];
      end
      // duty halves land here at any time; channels load them later
      for (int c = 0; c < pwts_pkg::NUM_CH; c++) begin
        if (wrIdx == pwts_pkg::IDX_DUTY_HI0 + 10'(c))
          dutyHi_reg[c] <= s_axi_wdata[7:0];
        if (wrIdx == pwts_pkg::IDX_DUTY_LO0 + 10'(c))
          dutyLo_reg[c] <= s_axi_wdata[pwts_pkg::DUTY_LO_LSB +: 2];
        if (wrIdx == pwts_pkg::IDX_CH_CTRL0 + 10'(c))
          chCtrl_reg[c] <= {s_axi_wdata[pwts_pkg::CTRL_EN_BIT],
                            s_axi_wdata[pwts_pkg::CTRL_POL_BIT]};
      end
    end
  end

  // read mux; reserved bits read zero
  assign rdIdx = s_axi_araddr[pwts_pkg::ADDR_W-1:2];
  always_comb begin
    rdOk   = 1'b1;
    rdByte = 8'h00;
    if (rdIdx == pwts_pkg::IDX_CC_SEL) rdByte = ccSel_reg;
    else if (rdIdx == pwts_pkg::IDX_PWM_SEL) rdByte = pwmSel_reg;
    else if (rdIdx == pwts_pkg::IDX_PIN_DIR) rdByte = {6'h00, pinDir_reg};
    else if (inBlock(rdIdx, pwts_pkg::IDX_TMR_CTRL0, pwts_pkg::NUM_TMR))
      rdByte = {5'h00, tmrCtrl_reg[2'(rdIdx - pwts_pkg::IDX_TMR_CTRL0)]};
    else if (inBlock(rdIdx, pwts_pkg::IDX_TMR_PER0, pwts_pkg::NUM_TMR))
      rdByte = tmrPer_reg[2'(rdIdx - pwts_pkg::IDX_TMR_PER0)];
    else if (inBlock(rdIdx, pwts_pkg::IDX_TMR_CNT0, pwts_pkg::NUM_TMR))
      rdByte = tBase[2'(rdIdx - pwts_pkg::IDX_TMR_CNT0)][9:2];
    else if (inBlock(rdIdx, pwts_pkg::IDX_DUTY_HI0, pwts_pkg::NUM_CH))
      rdByte = dutyHi_reg[1'(rdIdx - pwts_pkg::IDX_DUTY_HI0)];
    else if (inBlock(rdIdx, pwts_pkg::IDX_DUTY_LO0, pwts_pkg::NUM_CH))
      rdByte = {dutyLo_reg[1'(rdIdx - pwts_pkg::IDX_DUTY_LO0)], 6'h00};
    else if (inBlock(rdIdx, pwts_pkg::IDX_CH_CTRL0, pwts_pkg::NUM_CH))
      rdByte = {chCtrl_reg[1'(rdIdx - pwts_pkg::IDX_CH_CTRL0)][1], 1'b0,
                chLevel[1'(rdIdx - pwts_pkg::IDX_CH_CTRL0)],
                chCtrl_reg[1'(rdIdx - pwts_pkg::IDX_CH_CTRL0)][0], 4'h0};
    else rdOk = 1'b0; // unmapped: error answer, zero data
  end

  // read handshake: ready for one cycle, data the edge after
  assign rdFire = s_axi_arvalid && !arready_reg && !rvalid_reg;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= pwts_pkg::RESP_OKAY;
      rdata_reg   <= 32'h00000000;
    end else begin
      arready_reg <= rdFire;
      if (arready_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= {24'h000000, rdByte};
        rresp_reg  <= rdOk ? pwts_pkg::RESP_OKAY : pwts_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ports from flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = awready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign pwmOut        = pwmOut_reg;
  assign pwmOe         = pwmOe_reg;
  assign ccTimerPair   = ccPair_reg;
endmodule : pwts_top

// ==== tb/pwts_checker.sv ====
// port assertions for the ten-bit pwm block
module pwts_checker (
  input wire logic                          sys_clk,
  input wire logic                          rstn,
  input wire logic                          s_axi_awvalid,
  input wire logic                          s_axi_awready,
  input wire logic                          s_axi_wvalid,
  input wire logic                          s_axi_wready,
  input wire logic [1:0]                    s_axi_bresp,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic [31:0]                   s_axi_rdata,
  input wire logic                          s_axi_rvalid,
  input wire logic                          s_axi_rready,
  input wire logic                          sleepReq,
  input wire logic [pwts_pkg::NUM_CH-1:0]   pwmOut,
  input wire logic [pwts_pkg::NUM_CH-1:0]   pwmOe,
  input wire logic [2*pwts_pkg::NUM_CC-1:0] ccTimerPair
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // both halves taken together, response two cycles later
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid &&
    !s_axi_awready && !s_axi_bvalid |=> s_axi_awready && s_axi_wready
    ##1 s_axi_bvalid) else $error("write not answered in time");
  ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready &&
    s_axi_bvalid) else $error("write ready not a single pulse");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
  rd_answer_a: assert property (s_axi_arvalid && !s_axi_arready &&
    !s_axi_rvalid |=> s_axi_arready ##1 s_axi_rvalid)
    else $error("read not answered in time");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  pair_code_a: assert property (
    (ccTimerPair & (ccTimerPair >> 1) & 8'h55) == 8'h0)
    else $error("unknown timer pair code");
  // configuration outputs move only right after a register write
  cfg_cause_a: assert property ($changed({pwmOe, ccTimerPair}) |->
    $past(s_axi_awready) || $past(s_axi_awready, 2))
    else $error("config output changed without a write");
  rst_out_a: assert property (disable iff (1'h0) !rstn |=>
    pwmOe == 2'h0 && ccTimerPair == 8'h0 && !s_axi_bvalid)
    else $error("outputs not cleared by reset");
  sleep_hold_a: assert property (sleepReq [*8] |=>
    $stable(pwmOut)) else $error("output moved while asleep");
endmodule : pwts_checker

// ==== tb/pwts_load.sv ====
// load on the pwm pins: pull-down when undriven, counts high cycles
module pwts_load (
  input  wire logic        sys_clk,
  input  wire logic        clr,     // clear both counters
  input  wire logic        meas,    // count while high
  input  wire logic [1:0]  pinOut,  // driven level
  input  wire logic [1:0]  pinOe,   // high while driven
  output logic      [15:0] hiCnt0,  // high cycles, pin zero
  output logic      [15:0] hiCnt1   // high cycles, pin one
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pin; // resolved pin level
  // an undriven pin sits at the pull-down, not at its last level
  assign pin = pinOut & pinOe;
  // whole periods are counted so the window phase does not matter
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      hiCnt0 <= 16'h0;
      hiCnt1 <= 16'h0;
    end else if (meas) begin
      hiCnt0 <= hiCnt0 + 16'(pin[0]);
      hiCnt1 <= hiCnt1 + 16'(pin[1]);
    end
  end
endmodule : pwts_load

// ==== tb/pwts_top_tb.sv ====
// bench of the pwm block: registers, timer select and waveforms
module pwts_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'h0, rstn = 1'h0, sleepReq = 1'h0;
  logic [11:0] awAddr = 12'h0, arAddr = 12'h0;
  logic [31:0] wData = 32'h0;
  logic        awValid = 1'h0, wValid = 1'h0, bReady = 1'h0;
  logic        arValid = 1'h0, rReady = 1'h0, clr = 1'h0, meas = 1'h0;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic [1:0]  bResp, rResp, pwmOut, pwmOe;
  logic [31:0] rData;
  logic [7:0]  ccTimerPair;
  logic [15:0] hiCnt0, hiCnt1;
  int          mismatches = 0, checks = 0, cyc = 0, seed = 4382;
  always #2 sys_clk = ~sys_clk;
  pwts_top u_pwts_top (.sys_clk(sys_clk), .rstn(rstn),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .sleepReq(sleepReq),
    .pwmOut(pwmOut), .pwmOe(pwmOe), .ccTimerPair(ccTimerPair));
  pwts_load u_pwts_load (.sys_clk(sys_clk), .clr(clr), .meas(meas),
    .pinOut(pwmOut), .pinOe(pwmOe), .hiCnt0(hiCnt0), .hiCnt1(hiCnt1));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // response ready comes a cycle late so a waiting response is seen
  task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    @(posedge sys_clk);
    awAddr  <= {idx, 2'h0};
    wData   <= {24'h0, d};
    awValid <= 1'h1;
    wValid  <= 1'h1;
    do @(posedge sys_clk); while (awReady !== 1'h1);
    awValid <= 1'h0;
    wValid  <= 1'h0;
    @(posedge sys_clk);
    bReady  <= 1'h1;
    do @(posedge sys_clk); while (!(bValid === 1'h1 && bReady));
    bReady  <= 1'h0;
    chk(32'(bResp), 32'(er));
  endtask : wr
  task automatic rd(input logic [9:0] idx, input logic [31:0] ev,
                    input logic [1:0] er);
    @(posedge sys_clk);
    arAddr  <= {idx, 2'h0};
    arValid <= 1'h1;
    do @(posedge sys_clk); while (arReady !== 1'h1);
    arValid <= 1'h0;
    @(posedge sys_clk);
    rReady  <= 1'h1;
    do @(posedge sys_clk); while (!(rValid === 1'h1 && rReady));
    rReady  <= 1'h0;
    chk(rData, ev);
    chk(32'(rResp), 32'(er));
  endtask : rd
  // field 10 gives pair two, 11 pair three, 01 and reserved 00 pair one
  function automatic logic [7:0] pair_exp(input logic [7:0] v);
    for (int k = 0; k < 4; k++) begin
      pair_exp[2*k+:2] = (v[2*k+:2] == 2'h3) ? 2'h2 :
                         (v[2*k+:2] == 2'h2) ? 2'h1 : 2'h0;
    end
  endfunction : pair_exp
  // high cycles in a window of whole periods; duty caps at the period
  function automatic logic [31:0] hi_exp(input int d, p, ps, w,
                                         input logic en, output_invert_bit);
    int h;
    h = (d < 4*(p+1) ? d : 4*(p+1)) * ps * (w / ((p+1)*4*ps));
    if (!en) h = 0;
    return 32'(output_invert_bit ? w - h : h);
  endfunction : hi_exp
  // hang guard, well above the longest expected run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    int p0, p1, w;
    logic [9:0] d[2];
    logic [7:0] v, ctl[2];
    repeat (5) @(posedge sys_clk);
    rstn <= 1'h1;
    rd(pwts_pkg::IDX_CC_SEL, 32'h55, pwts_pkg::RESP_OKAY);
    rd(pwts_pkg::IDX_PWM_SEL, 32'h14, pwts_pkg::RESP_OKAY);
    rd(pwts_pkg::IDX_PIN_DIR, 32'h3, pwts_pkg::RESP_OKAY);
    rd(pwts_pkg::IDX_CH_CTRL0, 32'h0, pwts_pkg::RESP_OKAY);
    rd(10'h3ff, 32'h0, pwts_pkg::RESP_SLVERR);
    wr(pwts_pkg::IDX_TMR_CNT0, 8'h12, pwts_pkg::RESP_SLVERR);
    // every field code first, then random codes
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'he4 : 8'($random(seed));
      wr(pwts_pkg::IDX_CC_SEL, v, pwts_pkg::RESP_OKAY);
      chk(32'(ccTimerPair), 32'(pair_exp(v)));
    end
    p0 = $random(seed) & 7;
    p1 = $random(seed) & 7;
    w = (p0 + 1) * 4 * (p1 + 1) * 16;
    wr(pwts_pkg::IDX_TMR_PER0, 8'(p0), pwts_pkg::RESP_OKAY);
    wr(pwts_pkg::IDX_TMR_PER0 + 10'h1, 8'(p1), pwts_pkg::RESP_OKAY);
    wr(pwts_pkg::IDX_TMR_PER0 + 10'h2, 8'(p1), pwts_pkg::RESP_OKAY);
    wr(pwts_pkg::IDX_PIN_DIR, 8'h0, pwts_pkg::RESP_OKAY);
    chk(32'(pwmOe), 32'h3);
    // timers two and six at prescale one, timer four at four
    wr(pwts_pkg::IDX_TMR_CTRL0, 8'h1, pwts_pkg::RESP_OKAY);
    wr(pwts_pkg::IDX_TMR_CTRL0 + 10'h1, 8'h3, pwts_pkg::RESP_OKAY);
    wr(pwts_pkg::IDX_TMR_CTRL0 + 10'h2, 8'h1, pwts_pkg::RESP_OKAY);
    for (int i = 0; i < 10; i++) begin
      d[0] = 10'(($random(seed) & 255) % (4*p0 + 6));
      d[1] = 10'(($random(seed) & 255) % (4*p1 + 6));
      if (i < 3) d[0] = (i == 0) ? 10'h0 : (i == 1) ? 10'(4*p0 + 4) : 10'h3ff;
      v = 8'($random(seed));
      ctl[0] = {v[0] | (i < 3), 2'h0, v[2], 4'h0};
      ctl[1] = {v[1], 2'h0, v[3], 4'h0};
      for (int c = 0; c < 2; c++) begin
        wr(pwts_pkg::IDX_DUTY_HI0 + 10'(c), d[c][9:2], 2'h0);
        wr(pwts_pkg::IDX_DUTY_LO0 + 10'(c), {d[c][1:0], 6'h0}, 2'h0);
        wr(pwts_pkg::IDX_CH_CTRL0 + 10'(c), ctl[c], 2'h0);
      end
      wr(pwts_pkg::IDX_PWM_SEL, {3'h1, v[4], 4'h4}, 2'h0);
      repeat ((p0 + 1) * 8 + (p1 + 1) * 32 + 8) @(posedge sys_clk);
      clr  <= 1'h1;
      @(posedge sys_clk);
      clr  <= 1'h0;
      meas <= 1'h1;
      repeat (w) @(posedge sys_clk);
      meas <= 1'h0;
      @(posedge sys_clk);
      chk(32'(hiCnt0), hi_exp(d[0], p0, 1, w, ctl[0][7], ctl[0][4]));
      chk(32'(hiCnt1), hi_exp(d[1], p1, v[4] ? 1 : 4, w, ctl[1][7],
                              ctl[1][4]));
      // full duty and enabled: the level bit reads the inverse of polarity
      if (i == 2)
        rd(pwts_pkg::IDX_CH_CTRL0, ctl[0][4] ? 32'h90 : 32'ha0, 2'h0);
    end
    sleepReq <= 1'h1;
    repeat (12) @(posedge sys_clk);
    v[1:0] = pwmOut;
    repeat (100) @(posedge sys_clk);
    chk(32'(pwmOut), 32'(v[1:0]));
    sleepReq <= 1'h0;
    rstn <= 1'h0;
    repeat (2) @(posedge sys_clk);
    chk(32'(pwmOe), 32'h0);
    rstn <= 1'h1;
    rd(pwts_pkg::IDX_CH_CTRL0, 32'h0, pwts_pkg::RESP_OKAY);
    report_and_stop();
  end
endmodule : pwts_top_tb
bind pwts_top pwts_checker u_pwts_checker (.sys_clk(sys_clk),
  .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .sleepReq(sleepReq), .pwmOut(pwmOut),
  .pwmOe(pwmOe), .ccTimerPair(ccTimerPair));
